// ### shared/uart_cfg_params.svh
`ifndef UART_CFG_PARAMS_SVH
`define UART_CFG_PARAMS_SVH

// -------------------------------------------------------------------------
// Request decode
// -------------------------------------------------------------------------
`define REQ_TYPE_VENDOR_OUT 8'h40
`define REQ_TYPE_VENDOR_IN 8'hC0
`define REQ_CODE_VENDOR_REG 8'h05
`define REQ_TYPE_CLASS_OUT 8'h21
`define REQ_CODE_SET_LINE_CODING 8'h20
`define READ_REPLY_LEN 16'h0002

// -------------------------------------------------------------------------
// Register offsets
// -------------------------------------------------------------------------
`define OFS_TX_RX_ENABLE 16'h0040
`define OFS_CHAR_FORMAT 16'h0045
`define OFS_HANDSHAKE_MODE 16'h0046
`define OFS_RESUME_CHAR 16'h0047
`define OFS_PAUSE_CHAR 16'h0048
`define OFS_LINE_ERROR 16'h0049
`define OFS_BREAK_DURATION 16'h004A
`define OFS_TAIL_DELAY 16'h004B
`define OFS_PIN_FUNCTION 16'h004C
`define OFS_PIN_DIRECTION 16'h004D
`define OFS_PIN_OUT_SET 16'h004E
`define OFS_PIN_OUT_CLEAR 16'h004F
`define OFS_PIN_LEVEL 16'h0050
`define OFS_PIN_EVENT_MASK 16'h0051
`define OFS_CUSTOM_EVENT 16'h0052
`define OFS_PULL_UP 16'h0054
`define OFS_PULL_DOWN 16'h0055
`define OFS_LOOP_TEST 16'h0056
`define OFS_INFRARED 16'h0057
`define OFS_WAKE_SOURCE 16'h005F
`define OFS_SEND_FLUSH 16'h0060
`define OFS_SEND_LEVEL 16'h0061
`define OFS_SEND_WIDE 16'h0062
`define OFS_RECV_FLUSH 16'h0063
`define OFS_RECV_LEVEL 16'h0064
`define OFS_RECV_WIDE 16'h0065
`define OFS_RECV_PACKET 16'h0066
`define OFS_FILL_THRESHOLD 16'h0067
`define OFS_VENDOR_DRIVER 16'h0081

// -------------------------------------------------------------------------
// Fields and reset values
// -------------------------------------------------------------------------
`define EN_TX_BIT 0
`define EN_RX_BIT 1
`define EN_USED_MASK 16'h0003
`define FMT_STOP_BIT 7
`define FMT_PAR_LSB 4
`define FMT_WIDTH_LSB 0
`define FMT_USED_MASK 16'h00FF
`define LOW_BYTE_MASK 16'h00FF
`define RST_TX_RX_ENABLE 16'h0000
`define RST_CHAR_FORMAT 16'h0008
`define RST_ZERO 16'h0000
`define REG_COUNT 29
`define REG_INDEX_W 5
`define LINE_CODING_LEN 7
`endif

// ### shared/uart_cfg_pkg.sv
package uart_cfg_pkg;
    typedef enum logic [2:0]
    {
        PAR_NONE = 3'h0,
        PAR_ODD = 3'h1,
        PAR_EVEN = 3'h2,
        PAR_MARK = 3'h3,
        PAR_SPACE = 3'h4
    } parity_mode_t;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_DATA = 2'b01,
        ST_APPLY = 2'b11
    } coding_state_t;
endpackage

// ### core/cfg_reg_memory.sv
`timescale 1ns/1ps
`include "uart_cfg_params.svh"
// Small register memory for the plain read/write locations
module cfg_reg_memory
#(
    parameter int DEPTH = `REG_COUNT,
    parameter int AW = `REG_INDEX_W
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_index,
    input wire logic [15:0] wr_data,
    // Read port
    input wire logic [AW-1:0] rd_index,
    output logic [15:0] rd_data
);
    logic [15:0] cells [DEPTH];

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                cells[i] <= `RST_ZERO;
            end
        end
        else if (wr_en)
        begin
            cells[wr_index] <= wr_data;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_data <= `RST_ZERO;
        end
        else
        begin
            // Slots past the depth hold no register and read as zero
            rd_data <= (int'(rd_index) < DEPTH) ? cells[rd_index] : `RST_ZERO;
        end
    end
endmodule // cfg_reg_memory

// ### core/uart_config_register_bank.sv
`timescale 1ns/1ps
`include "uart_cfg_params.svh"
module uart_config_register_bank
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control request from the USB device controller (setup stage)
    input wire logic setup_valid,
    input wire logic [7:0] req_type,
    input wire logic [7:0] req_code,
    input wire logic [15:0] req_value,
    input wire logic [15:0] req_index,
    input wire logic [15:0] req_length,
    // Data stage bytes of class requests
    input wire logic data_valid,
    input wire logic [7:0] data_byte,
    // Reply for get-register requests
    output logic reply_valid,
    output logic [15:0] reply_data,
    output logic req_stall,
    // Status from the UART core
    input wire logic [15:0] line_error_status,
    input wire logic [15:0] pin_level_status,
    input wire logic [15:0] send_level_status,
    input wire logic [15:0] recv_level_status,
    // Configuration towards the UART core
    output logic tx_enable,
    output logic rx_enable,
    output logic two_stop_bits,
    output uart_cfg_pkg::parity_mode_t parity_mode,
    output logic [3:0] char_width
);
    import uart_cfg_pkg::*;

    // -------------------------------------------------------------------------
    // Request decode
    // -------------------------------------------------------------------------
    logic is_write;
    logic is_read;
    logic is_coding;
    logic [15:0] addr;

    // Map a register address to its memory slot, or flag it as unmapped
    function automatic logic [5:0] slot_of(input logic [15:0] a);
        logic [5:0] s;
        s = 6'h3F;
        unique case (a)
            `OFS_HANDSHAKE_MODE: s = 6'd0;
            `OFS_RESUME_CHAR: s = 6'd1;
            `OFS_PAUSE_CHAR: s = 6'd2;
            `OFS_BREAK_DURATION: s = 6'd3;
            `OFS_TAIL_DELAY: s = 6'd4;
            `OFS_PIN_FUNCTION: s = 6'd5;
            `OFS_PIN_DIRECTION: s = 6'd6;
            `OFS_PIN_OUT_SET: s = 6'd7;
            `OFS_PIN_OUT_CLEAR: s = 6'd8;
            `OFS_PIN_EVENT_MASK: s = 6'd9;
            `OFS_CUSTOM_EVENT: s = 6'd10;
            `OFS_PULL_UP: s = 6'd11;
            `OFS_PULL_DOWN: s = 6'd12;
            `OFS_LOOP_TEST: s = 6'd13;
            `OFS_INFRARED: s = 6'd14;
            `OFS_WAKE_SOURCE: s = 6'd15;
            `OFS_SEND_FLUSH: s = 6'd16;
            `OFS_SEND_WIDE: s = 6'd17;
            `OFS_RECV_FLUSH: s = 6'd18;
            `OFS_RECV_WIDE: s = 6'd19;
            `OFS_RECV_PACKET: s = 6'd20;
            `OFS_FILL_THRESHOLD: s = 6'd21;
            `OFS_VENDOR_DRIVER: s = 6'd22;
            default: s = 6'h3F;
        endcase
        return s;
    endfunction

    always_comb
    begin
        addr = req_index;
        is_write = setup_valid && req_type == `REQ_TYPE_VENDOR_OUT
            && req_code == `REQ_CODE_VENDOR_REG;
        is_read = setup_valid && req_type == `REQ_TYPE_VENDOR_IN
            && req_code == `REQ_CODE_VENDOR_REG
            && req_length == `READ_REPLY_LEN;
        is_coding = setup_valid && req_type == `REQ_TYPE_CLASS_OUT
            && req_code == `REQ_CODE_SET_LINE_CODING;
    end

    logic [5:0] wslot;
    logic mem_wr;
    assign wslot = slot_of(addr);
    // Unmapped or read-only addresses are not stored
    assign mem_wr = is_write && wslot != 6'h3F;

    // -------------------------------------------------------------------------
    // Enable register
    // -------------------------------------------------------------------------
    logic [15:0] enable_reg;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            enable_reg <= `RST_TX_RX_ENABLE;
        end
        else if (is_write && addr == `OFS_TX_RX_ENABLE)
        begin
            enable_reg <= req_value & `EN_USED_MASK;
        end
    end

    assign tx_enable = enable_reg[`EN_TX_BIT];
    assign rx_enable = enable_reg[`EN_RX_BIT];

    // -------------------------------------------------------------------------
    // Line coding capture (seven data bytes)
    // -------------------------------------------------------------------------
    coding_state_t cstate;
    logic [2:0] byte_cnt;
    logic [7:0] stop_code;
    logic [7:0] par_code;
    logic [7:0] width_code;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cstate <= ST_IDLE;
            byte_cnt <= 3'h0;
            stop_code <= 8'h00;
            par_code <= 8'h00;
            width_code <= 8'h00;
        end
        else
        begin
            unique case (cstate)
                ST_IDLE:
                begin
                    byte_cnt <= 3'h0;
                    if (is_coding)
                    begin
                        cstate <= ST_DATA;
                    end
                end
                ST_DATA:
                begin
                    if (data_valid)
                    begin
                        unique case (byte_cnt)
                            3'd4: stop_code <= data_byte;
                            3'd5: par_code <= data_byte;
                            3'd6: width_code <= data_byte;
                            default: ;
                        endcase
                        byte_cnt <= byte_cnt + 3'h1;
                        if (byte_cnt == 3'(`LINE_CODING_LEN - 1))
                        begin
                            cstate <= ST_APPLY;
                        end
                    end
                end
                ST_APPLY:
                begin
                    cstate <= ST_IDLE;
                end
                default: cstate <= ST_IDLE;
            endcase
        end
    end

    // Translate class coding into the format register layout
    function automatic logic [15:0] coding_to_format(input logic [7:0] st,
        input logic [7:0] pa, input logic [7:0] wd);
        logic [15:0] f;
        f = `RST_ZERO;
        f[`FMT_STOP_BIT] = (st != 8'h00);
        f[`FMT_PAR_LSB +: 3] = (pa <= 8'h04) ? pa[2:0] : 3'h0;
        f[`FMT_WIDTH_LSB +: 4] = (wd == 8'h10) ? 4'h9 : wd[3:0];
        return f;
    endfunction

    // -------------------------------------------------------------------------
    // Format register
    // -------------------------------------------------------------------------
    logic [15:0] format_reg;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            format_reg <= `RST_CHAR_FORMAT;
        end
        else if (is_write && addr == `OFS_CHAR_FORMAT)
        begin
            format_reg <= req_value & `FMT_USED_MASK;
        end
        else if (cstate == ST_APPLY)
        begin
            format_reg <= coding_to_format(stop_code, par_code, width_code);
        end
    end

    assign two_stop_bits = format_reg[`FMT_STOP_BIT];
    assign parity_mode = parity_mode_t'(format_reg[`FMT_PAR_LSB +: 3]);
    assign char_width = format_reg[`FMT_WIDTH_LSB +: 4];

    // -------------------------------------------------------------------------
    // Register memory and read path
    // -------------------------------------------------------------------------
    logic [15:0] mem_rd;
    logic [15:0] masked_wr;

    // Other locations are 16 bits wide; the upper byte is stored as written, not masked
    assign masked_wr = req_value;

    cfg_reg_memory #(
        .DEPTH(`REG_COUNT),
        .AW(`REG_INDEX_W)
    ) u_mem (
        .clk(clk),
        .rstn(rstn),
        .wr_en(mem_wr),
        .wr_index(wslot[`REG_INDEX_W-1:0]),
        .wr_data(masked_wr),
        .rd_index(wslot[`REG_INDEX_W-1:0]),
        .rd_data(mem_rd)
    );

    logic rd_pend;
    logic [15:0] rd_addr;
    logic rd_bad;
    logic [15:0] reply_data_next;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rd_pend <= 1'b0;
            rd_addr <= `RST_ZERO;
        end
        else
        begin
            rd_pend <= is_read;
            if (is_read)
            begin
                rd_addr <= addr;
            end
        end
    end

    always_comb
    begin
        rd_bad = 1'b0;
        unique case (rd_addr)
            `OFS_TX_RX_ENABLE: reply_data_next = enable_reg;
            `OFS_CHAR_FORMAT: reply_data_next = format_reg;
            `OFS_LINE_ERROR: reply_data_next = line_error_status & `LOW_BYTE_MASK;
            `OFS_PIN_LEVEL: reply_data_next = pin_level_status & `LOW_BYTE_MASK;
            `OFS_SEND_LEVEL: reply_data_next = send_level_status;
            `OFS_RECV_LEVEL: reply_data_next = recv_level_status;
            default:
            begin
                reply_data_next = mem_rd;
                rd_bad = (slot_of(rd_addr) == 6'h3F);
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reply_valid <= 1'b0;
            reply_data <= `RST_ZERO;
            req_stall <= 1'b0;
        end
        else
        begin
            reply_valid <= rd_pend && !rd_bad;
            reply_data <= (rd_pend && !rd_bad) ? reply_data_next : `RST_ZERO;
            req_stall <= rd_pend && rd_bad;
        end
    end
endmodule // uart_config_register_bank

// ### tb/host_model.sv
`timescale 1ns/1ps
`include "uart_cfg_params.svh"
module host_model
(
    // Clock and answers
    input wire logic clk,
    input wire logic reply_valid,
    input wire logic [15:0] reply_data,
    input wire logic req_stall,
    // Requests
    output logic setup_valid,
    output logic [7:0] req_type,
    output logic [7:0] req_code,
    output logic [15:0] req_value,
    output logic [15:0] req_index,
    output logic [15:0] req_length,
    output logic data_valid,
    output logic [7:0] data_byte
);
    initial
    begin
        {setup_valid, req_type, req_code, req_value, req_index, req_length} = '0;
        {data_valid, data_byte} = '0;
    end
    // One setup pulse; value and index fields are inverted afterwards
    task automatic setup(input logic [7:0] t, input logic [7:0] c, input logic [15:0] v,
        input logic [15:0] i, input logic [15:0] l);
        @(posedge clk);
        setup_valid <= 1'b1;
        {req_type, req_code, req_value, req_index, req_length} <= {t, c, v, i, l};
        @(posedge clk);
        setup_valid <= 1'b0;
        {req_value, req_index} <= ~{v, i};
    endtask
    // Writes go only to defined addresses
    task automatic wr(input logic [15:0] a, input logic [15:0] v);
        setup(`REQ_TYPE_VENDOR_OUT, `REQ_CODE_VENDOR_REG, v, a, 16'h0000);
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic st,
        output logic ok);
        ok = 1'b0;
        setup(`REQ_TYPE_VENDOR_IN, `REQ_CODE_VENDOR_REG, 16'h0000, a, `READ_REPLY_LEN);
        for (int n = 0; n < 8 && !ok; n++)
        begin
            @(posedge clk);
            #1;
            ok = (reply_valid === 1'b1) || (req_stall === 1'b1);
            d = reply_data;
            st = req_stall;
        end
    endtask
    // Only listed parity and width codes are sent, the other four bytes are 8'h60
    task automatic coding(input logic [7:0] stop, input logic [7:0] par, input logic [7:0] w);
        setup(`REQ_TYPE_CLASS_OUT, `REQ_CODE_SET_LINE_CODING, 16'h0000, 16'h0000, 16'h0007);
        for (int k = 0; k < 7; k++)
        begin
            data_valid <= 1'b1;
            data_byte <= (k == 4) ? stop : (k == 5) ? par : (k == 6) ? w : 8'h60;
            @(posedge clk);
        end
        data_valid <= 1'b0;
        data_byte <= ~data_byte;
    endtask
endmodule // host_model

// ### tb/uart_cfg_properties.sv
`timescale 1ns/1ps
`include "uart_cfg_params.svh"
module uart_cfg_properties
(
    // Clock, reset and requests
    input wire logic clk,
    input wire logic rstn,
    input wire logic setup_valid,
    input wire logic [7:0] req_type,
    input wire logic [7:0] req_code,
    input wire logic [15:0] req_value,
    input wire logic [15:0] req_index,
    input wire logic [15:0] req_length,
    input wire logic data_valid,
    // Answers and configuration
    input wire logic reply_valid,
    input wire logic [15:0] reply_data,
    input wire logic req_stall,
    input wire logic tx_enable,
    input wire logic rx_enable,
    input wire logic two_stop_bits,
    input wire uart_cfg_pkg::parity_mode_t parity_mode,
    input wire logic [3:0] char_width
);
    import uart_cfg_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic rd_req;
    logic wr_req;
    logic [15:0] last_value;
    logic [7:0] fmt;
    assign rd_req = setup_valid && req_type == `REQ_TYPE_VENDOR_IN
        && req_code == `REQ_CODE_VENDOR_REG && req_length == `READ_REPLY_LEN;
    assign wr_req = setup_valid && req_type == `REQ_TYPE_VENDOR_OUT
        && req_code == `REQ_CODE_VENDOR_REG;
    assign fmt = {two_stop_bits, parity_mode, char_width};
    always_ff @(posedge clk)
    begin
        last_value <= req_value;
    end
    a_enable_write: assert property (wr_req && req_index == `OFS_TX_RX_ENABLE
        |=> {rx_enable, tx_enable} == last_value[1:0]) else $error("enable write not applied");
    a_format_write: assert property (wr_req && req_index == `OFS_CHAR_FORMAT
        |=> fmt == last_value[7:0]) else $error("format write not applied");
    a_reply_timing: assert property (rd_req |-> ##2 (reply_valid != req_stall))
        else $error("read answer not on second cycle");
    a_reply_cause: assert property (reply_valid |-> $past(rd_req, 2))
        else $error("reply without read");
    a_enable_readback: assert property (rd_req && req_index == `OFS_TX_RX_ENABLE
        |-> ##2 reply_valid && reply_data == {14'h0000, rx_enable, tx_enable})
        else $error("enable readback wrong");
    a_format_readback: assert property (rd_req && req_index == `OFS_CHAR_FORMAT
        |-> ##2 reply_valid && reply_data == {8'h00, fmt}) else $error("format readback wrong");
    a_stall_unmapped: assert property (rd_req && req_index inside {[16'h0041:16'h0044]}
        |-> ##2 req_stall && !reply_valid) else $error("unmapped read not stalled");
    a_format_cause: assert property ($changed(fmt)
        |-> $past(setup_valid) || $past(data_valid, 2) || $past(data_valid, 3))
        else $error("format changed without request");
    cover property (wr_req);
    cover property (rd_req ##2 req_stall);
    cover property (data_valid ##1 !data_valid);
endmodule // uart_cfg_properties
bind uart_config_register_bank uart_cfg_properties uart_cfg_properties_inst (
    .clk(clk), .rstn(rstn), .setup_valid(setup_valid), .req_type(req_type),
    .req_code(req_code), .req_value(req_value), .req_index(req_index),
    .req_length(req_length), .data_valid(data_valid), .reply_valid(reply_valid),
    .reply_data(reply_data), .req_stall(req_stall), .tx_enable(tx_enable),
    .rx_enable(rx_enable), .two_stop_bits(two_stop_bits), .parity_mode(parity_mode),
    .char_width(char_width)
);

// ### tb/tb_top.sv
`timescale 1ns/1ps
`include "uart_cfg_params.svh"
module tb_top;
    import uart_cfg_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic setup_valid, data_valid, reply_valid, req_stall;
    logic tx_enable, rx_enable, two_stop_bits;
    logic [7:0] req_type, req_code, data_byte;
    logic [15:0] req_value, req_index, req_length, reply_data;
    logic [15:0] err_st = 16'hA5F8, pin_st = 16'h0015, send_st = 16'h0123, recv_st = 16'h0456;
    logic [3:0] char_width;
    parity_mode_t parity_mode;
    int bad_count = 0;
    int n_checks = 0;
    always #25 clk = ~clk;
    uart_config_register_bank uart_config_register_bank_inst (.clk(clk), .rstn(rstn),
        .setup_valid(setup_valid), .req_type(req_type), .req_code(req_code),
        .req_value(req_value), .req_index(req_index), .req_length(req_length),
        .data_valid(data_valid), .data_byte(data_byte), .reply_valid(reply_valid),
        .reply_data(reply_data), .req_stall(req_stall), .line_error_status(err_st),
        .pin_level_status(pin_st), .send_level_status(send_st), .recv_level_status(recv_st),
        .tx_enable(tx_enable), .rx_enable(rx_enable), .two_stop_bits(two_stop_bits),
        .parity_mode(parity_mode), .char_width(char_width));
    host_model host_model_inst (.clk(clk), .reply_valid(reply_valid), .reply_data(reply_data),
        .req_stall(req_stall), .setup_valid(setup_valid), .req_type(req_type),
        .req_code(req_code), .req_value(req_value), .req_index(req_index),
        .req_length(req_length), .data_valid(data_valid), .data_byte(data_byte));
    task automatic conclude();
        $display("Checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [15:0] exp, input logic est);
        logic [15:0] d;
        logic st;
        logic ok;
        host_model_inst.rd(a, d, st, ok);
        chk("answer seen", 16'h0001, {15'h0000, ok});
        if (!ok)
            conclude();
        chk($sformatf("data at %h", a), exp, d);
        chk($sformatf("stall at %h", a), {15'h0000, est}, {15'h0000, st});
    endtask
    task automatic chk_outputs(input logic [15:0] en, input logic [15:0] f);
        chk("enable outputs", en, {14'h0000, rx_enable, tx_enable});
        chk("format outputs", f, {8'h00, two_stop_bits, parity_mode, char_width});
    endtask
    task automatic reset_values();
        chk_outputs(16'h0000, 16'h0008);
        rdchk(`OFS_TX_RX_ENABLE, 16'h0000, 1'b0);
        rdchk(`OFS_CHAR_FORMAT, 16'h0008, 1'b0);
        rdchk(`OFS_RESUME_CHAR, 16'h0000, 1'b0);
    endtask
    task automatic enable_bits();
        logic [15:0] v[4] = '{16'hFFFF, 16'h0002, 16'h0001, 16'h0000};
        foreach (v[i])
        begin
            host_model_inst.wr(`OFS_TX_RX_ENABLE, v[i]);
            rdchk(`OFS_TX_RX_ENABLE, v[i] & 16'h0003, 1'b0);
            chk_outputs(v[i] & 16'h0003, 16'h0008);
        end
    endtask
    task automatic format_codes();
        logic [15:0] v[6] = '{16'h0007, 16'h0098, 16'h0029, 16'hFFB8, 16'h00C7, 16'h0048};
        foreach (v[i])
        begin
            host_model_inst.wr(`OFS_CHAR_FORMAT, v[i]);
            rdchk(`OFS_CHAR_FORMAT, v[i] & 16'h00FF, 1'b0);
            chk_outputs(16'h0000, v[i] & 16'h00FF);
        end
    endtask
    task automatic plain_and_status();
        host_model_inst.wr(`OFS_HANDSHAKE_MODE, 16'h0009);
        host_model_inst.wr(`OFS_BREAK_DURATION, 16'hA5C3);
        host_model_inst.wr(`OFS_LINE_ERROR, 16'h0000);
        rdchk(`OFS_HANDSHAKE_MODE, 16'h0009, 1'b0);
        rdchk(`OFS_BREAK_DURATION, 16'hA5C3, 1'b0);
        rdchk(`OFS_LINE_ERROR, 16'h00F8, 1'b0);
        rdchk(`OFS_PIN_LEVEL, 16'h0015, 1'b0);
        rdchk(`OFS_SEND_LEVEL, 16'h0123, 1'b0);
        rdchk(`OFS_RECV_LEVEL, 16'h0456, 1'b0);
        rdchk(16'h0041, 16'h0000, 1'b1);
        rdchk(16'h0053, 16'h0000, 1'b1);
    endtask
    task automatic line_coding();
        host_model_inst.coding(8'h01, 8'h02, 8'h07);
        repeat (2) @(posedge clk);
        rdchk(`OFS_CHAR_FORMAT, 16'h00A7, 1'b0);
        chk_outputs(16'h0000, 16'h00A7);
        host_model_inst.coding(8'h00, 8'h00, 8'h10);
        repeat (2) @(posedge clk);
        rdchk(`OFS_CHAR_FORMAT, 16'h0009, 1'b0);
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        #1;
        reset_values();
        enable_bits();
        format_codes();
        plain_and_status();
        line_coding();
        conclude();
    end
endmodule // tb_top
